// *** hw/dsp_pkg.sv ***
package dsp_pkg;

  // byte and instruction layout
  localparam int unsigned DSP_BYTE_W = 8;
  localparam int unsigned DSP_ADDR_W = 7;
  localparam int unsigned DSP_CNT_W = 3;
  localparam int unsigned DSP_RW_BIT = 7;
  localparam logic [2:0] DSP_CNT_ZERO = 3'h0;
  localparam logic [2:0] DSP_CNT_STEP = 3'h1;
  localparam logic [2:0] DSP_CNT_LAST = 3'h7;

  // register map
  localparam logic [6:0] DSP_ADDR_SPCFG = 7'h00;
  localparam logic [6:0] DSP_ADDR_STATUS = 7'h01;
  localparam logic [6:0] DSP_ADDR_USER0 = 7'h02;
  localparam int unsigned DSP_NUM_USER = 4;

  // serial_port_config fields
  localparam int unsigned DSP_CFG_BIDIR = 7;
  localparam int unsigned DSP_CFG_LSB = 6;
  localparam int unsigned DSP_CFG_SRST = 5;
  localparam logic [7:0] DSP_SPCFG_RST = 8'h00;
  localparam logic [7:0] DSP_SPCFG_MASK = 8'hE0;
  localparam logic [7:0] DSP_USER_RST = 8'h00;
  localparam logic [7:0] DSP_BYTE_ZERO = 8'h00;

  // serial cycle phase
  typedef enum logic {
    DSP_PH_INSTR,
    DSP_PH_DATA
  } dsp_phase_e;

endpackage

// *** hw/dsp_sync2.sv ***
`timescale 1ns/1ps
module dsp_sync2
  import dsp_pkg::*;
#(
  parameter int unsigned WIDTH = DSP_BYTE_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // two-stage level synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // dsp_sync2

// *** hw/dsp_cfg_xfer.sv ***
`timescale 1ns/1ps
module dsp_cfg_xfer
  import dsp_pkg::*;
#(
  parameter int unsigned WIDTH = DSP_BYTE_W,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // source, link domain
  input wire logic tgl,
  input wire logic [WIDTH-1:0] img,
  // captured copy
  output logic [WIDTH-1:0] img_q
);

  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_seen_q;
  logic take;

  // new image on toggle change
  assign take = tgl_sync_q ^ tgl_seen_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_seen_q <= 1'b0;
      img_q <= RST_VAL;
    end
    else
    begin
      tgl_meta_q <= tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_seen_q <= tgl_sync_q;
      if (take)
      begin
        img_q <= img;
      end
    end
  end

endmodule // dsp_cfg_xfer

// *** hw/dsp_serial_port.sv ***
`timescale 1ns/1ps
// Function
// - instruction byte on first eight rising edges
// - exactly one data byte per instruction
// - register updates on last written bit
// - stall at byte boundary continues cycle
// - mid-byte chip select rise aborts cycle
// - instruction bit 7 one means read
// - instruction bits 6..0 are register address
// - inputs sampled on serial clock rising edge
// - read drive starts on falling edge
// - both data pins released while deselected
// - config bit 7 selects bidirectional data pin
// - bidirectional mode keeps output pin released
// - bit order default most significant first
// - bit order one means least significant first
// - config bits 7..5 act immediately
// - software reset restores all but config
// - zero bits recover port to default
module dsp_serial_port
  import dsp_pkg::*;
#(
  parameter int unsigned NUM_USER = DSP_NUM_USER,
  parameter logic [NUM_USER*DSP_BYTE_W-1:0] USER_RST =
    {NUM_USER{DSP_USER_RST}}
)
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe_n,
  // configuration image, system domain
  output logic cfg_bidir,
  output logic cfg_lsb_first,
  output logic [NUM_USER*DSP_BYTE_W-1:0] cfg_user,
  // status readback, system domain
  input wire logic [DSP_BYTE_W-1:0] status_in
);

  localparam int unsigned USER_W = NUM_USER * DSP_BYTE_W;
  localparam int unsigned IMG_W = USER_W + DSP_BYTE_W;
  localparam logic [IMG_W-1:0] IMG_RST = {USER_RST, DSP_SPCFG_RST};

  // shift one bit into a byte
  function automatic logic [DSP_BYTE_W-1:0] shift_in(
    input logic [DSP_BYTE_W-1:0] sh,
    input logic din,
    input logic lsb
  );
    if (lsb)
    begin
      shift_in = {din, sh[DSP_BYTE_W-1:1]};
    end
    else
    begin
      shift_in = {sh[DSP_BYTE_W-2:0], din};
    end
  endfunction

  // pick the n-th bit to send
  function automatic logic sel_bit(
    input logic [DSP_BYTE_W-1:0] data,
    input logic [DSP_CNT_W-1:0] idx,
    input logic lsb
  );
    if (lsb)
    begin
      sel_bit = data[idx];
    end
    else
    begin
      sel_bit = data[DSP_CNT_LAST - idx];
    end
  endfunction

  // user register address match
  function automatic logic user_hit(
    input logic [DSP_ADDR_W-1:0] addr,
    input int unsigned k
  );
    user_hit = (addr == DSP_ADDR_USER0 + k[DSP_ADDR_W-1:0]);
  endfunction

  // system side
  logic link_rst_q;
  logic [IMG_W-1:0] img_sys;

  // link side state
  dsp_phase_e phase_q;
  logic [DSP_CNT_W-1:0] cnt_q;
  logic [DSP_BYTE_W-1:0] sh_q;
  logic [DSP_ADDR_W-1:0] addr_q;
  logic rd_q;
  logic rd_act_q;
  logic [DSP_BYTE_W-1:0] rdata_q;
  logic dout_q;
  logic first_q;
  logic mid_q;
  logic [DSP_BYTE_W-1:0] spcfg_q;
  logic [USER_W-1:0] user_q;
  logic wr_tgl_q;
  logic sdio_oe_n_q;
  logic dout_pin_oe_n_q;
  logic [DSP_BYTE_W-1:0] status_s;

  // link side decode
  logic abort;
  dsp_phase_e phase_eff;
  logic [DSP_CNT_W-1:0] cnt_eff;
  logic [DSP_CNT_W-1:0] cnt_d;
  logic [DSP_BYTE_W-1:0] sh_d;
  logic lsb;
  logic bidir;
  logic byte_end;
  logic instr_end;
  logic data_end;
  logic rd_req;
  logic [DSP_ADDR_W-1:0] rd_addr;
  logic wr_stb;
  logic spcfg_wr;
  logic srst_stb;
  logic [DSP_BYTE_W-1:0] rd_mux;

  // link reset from system reset
  always_ff @(posedge clk_sys)
  begin
    link_rst_q <= ~rst_n;
  end

  // frame start marker
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
    end
  end

  assign abort = first_q & mid_q;
  assign cnt_eff = abort ? DSP_CNT_ZERO : cnt_q;
  assign phase_eff = abort ? DSP_PH_INSTR : phase_q;
  assign cnt_d = cnt_eff + DSP_CNT_STEP;

  assign lsb = spcfg_q[DSP_CFG_LSB];
  assign bidir = spcfg_q[DSP_CFG_BIDIR];

  assign sh_d = shift_in(sh_q, sdio_in, lsb);

  assign byte_end = (cnt_eff == DSP_CNT_LAST);
  assign instr_end = byte_end & (phase_eff == DSP_PH_INSTR);
  assign data_end = byte_end & (phase_eff == DSP_PH_DATA);

  assign rd_req = sh_d[DSP_RW_BIT];
  assign rd_addr = sh_d[DSP_ADDR_W-1:0];

  assign wr_stb = data_end & ~rd_q;
  assign spcfg_wr = wr_stb & (addr_q == DSP_ADDR_SPCFG);
  assign srst_stb = spcfg_wr & sh_d[DSP_CFG_SRST];

  // read data select
  always_comb
  begin
    rd_mux = DSP_BYTE_ZERO;
    if (rd_addr == DSP_ADDR_SPCFG)
    begin
      rd_mux = spcfg_q & DSP_SPCFG_MASK;
    end
    else if (rd_addr == DSP_ADDR_STATUS)
    begin
      rd_mux = status_s;
    end
    for (int unsigned k = 0; k < NUM_USER; k++)
    begin
      if (user_hit(rd_addr, k))
      begin
        rd_mux = user_q[k*DSP_BYTE_W +: DSP_BYTE_W];
      end
    end
  end

  always_ff @(posedge sclk or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      phase_q <= DSP_PH_INSTR;
      cnt_q <= DSP_CNT_ZERO;
      sh_q <= DSP_BYTE_ZERO;
      addr_q <= DSP_ADDR_SPCFG;
      rd_q <= 1'b0;
      rd_act_q <= 1'b0;
      rdata_q <= DSP_BYTE_ZERO;
      dout_q <= 1'b0;
      mid_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      mid_q <= (cnt_d != DSP_CNT_ZERO);
      sh_q <= sh_d;
      phase_q <= phase_eff;
      rd_act_q <= rd_act_q & ~abort;
      if (instr_end)
      begin
        phase_q <= DSP_PH_DATA;
        addr_q <= rd_addr;
        rd_q <= rd_req;
        rd_act_q <= rd_req;
        rdata_q <= rd_mux;
        dout_q <= sel_bit(rd_mux, DSP_CNT_ZERO, lsb);
      end
      else if (data_end)
      begin
        phase_q <= DSP_PH_INSTR;
        rd_act_q <= 1'b0;
      end
      else if (phase_eff == DSP_PH_DATA)
      begin
        // later read bits on rising edges
        dout_q <= sel_bit(rdata_q, cnt_d, lsb);
      end
    end
  end

  always_ff @(posedge sclk or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      spcfg_q <= DSP_SPCFG_RST;
      wr_tgl_q <= 1'b0;
    end
    else
    begin
      if (wr_stb)
      begin
        wr_tgl_q <= ~wr_tgl_q;
      end
      if (spcfg_wr)
      begin
        spcfg_q <= sh_d & DSP_SPCFG_MASK;
      end
    end
  end

  // user registers
  for (genvar k = 0; k < NUM_USER; k++)
  begin : g_user
    logic user_wr;

    assign user_wr = wr_stb & user_hit(addr_q, k);

    always_ff @(posedge sclk or posedge link_rst_q)
    begin
      if (link_rst_q)
      begin
        user_q[k*DSP_BYTE_W +: DSP_BYTE_W] <=
          USER_RST[k*DSP_BYTE_W +: DSP_BYTE_W];
      end
      else if (srst_stb)
      begin
        user_q[k*DSP_BYTE_W +: DSP_BYTE_W] <=
          USER_RST[k*DSP_BYTE_W +: DSP_BYTE_W];
      end
      else if (user_wr)
      begin
        user_q[k*DSP_BYTE_W +: DSP_BYTE_W] <= sh_d;
      end
    end
  end

  always_ff @(negedge sclk or posedge cs_n or posedge link_rst_q)
  begin
    if (cs_n || link_rst_q)
    begin
      sdio_oe_n_q <= 1'b1;
      dout_pin_oe_n_q <= 1'b1;
    end
    else
    begin
      sdio_oe_n_q <= ~(rd_act_q & bidir);
      dout_pin_oe_n_q <= ~(rd_act_q & ~bidir);
    end
  end

  // status into link domain
  dsp_sync2 #(
    .WIDTH(DSP_BYTE_W)
  ) u_status_sync (
    .clk(sclk),
    .rst(link_rst_q),
    .d(status_in),
    .q(status_s)
  );

  // register image into system domain
  dsp_cfg_xfer #(
    .WIDTH(IMG_W),
    .RST_VAL(IMG_RST)
  ) u_cfg_xfer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tgl(wr_tgl_q),
    .img({user_q, spcfg_q}),
    .img_q(img_sys)
  );

  // pins
  assign sdio_out = dout_q;
  assign sdio_oe_n = sdio_oe_n_q;
  assign serial_data_out_pin = dout_q;
  assign serial_data_out_pin_oe_n = dout_pin_oe_n_q;

  // system side config
  assign cfg_bidir = img_sys[DSP_CFG_BIDIR];
  assign cfg_lsb_first = img_sys[DSP_CFG_LSB];
  assign cfg_user = img_sys[IMG_W-1:DSP_BYTE_W];

endmodule // dsp_serial_port

// *** verification/dsp_serial_port_monitor.sv ***
`timescale 1ns/1ps
module dsp_serial_port_monitor
  import dsp_pkg::*;
#(
  parameter int unsigned NUM_USER = DSP_NUM_USER
)
(
  // clocks and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  // link pins
  input wire logic cs_n,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_pin_oe_n,
  // configuration image
  input wire logic cfg_bidir,
  input wire logic cfg_lsb_first,
  input wire logic [NUM_USER*DSP_BYTE_W-1:0] cfg_user
);
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  assign quiet_d = !cs_n ? 4'h0 : (&quiet_q ? quiet_q : quiet_q + 4'h1);
  always_ff @(posedge clk_sys)
  begin
    quiet_q <= !rst_n ? 4'h0 : quiet_d;
  end
  hiz_idle_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n && $past(cs_n) |-> sdio_oe_n && serial_data_out_pin_oe_n)
    else $error("pin driven while idle");
  pin_excl_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(!sdio_oe_n && !serial_data_out_pin_oe_n))
    else $error("both pins driven");
  sdio_len_a: assert property (
    @(posedge sclk) disable iff (!rst_n || cs_n)
    $fell(sdio_oe_n) |-> !sdio_oe_n [*8])
    else $error("shared pin drive length wrong");
  sdo_mode_a: assert property (
    @(negedge sclk) disable iff (!rst_n || cs_n)
    !serial_data_out_pin_oe_n |-> !cfg_bidir)
    else $error("output pin used in bidir");
  sdio_mode_a: assert property (
    @(negedge sclk) disable iff (!rst_n || cs_n)
    !sdio_oe_n |-> cfg_bidir)
    else $error("data pin driven in 4-wire");
  drive_len_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(serial_data_out_pin_oe_n) |-> !serial_data_out_pin_oe_n [*8]
    ##[1:20] serial_data_out_pin_oe_n)
    else $error("read drive length wrong");
  cfg_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    quiet_q >= 4'hA |-> $stable(cfg_user) && $stable(cfg_bidir)
    && $stable(cfg_lsb_first))
    else $error("config moved while idle");
  rst_dflt_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> cfg_user == '0 && !cfg_bidir && !cfg_lsb_first)
    else $error("config not default");
endmodule // dsp_serial_port_monitor

bind dsp_serial_port dsp_serial_port_monitor #(.NUM_USER(NUM_USER)) mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
  .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
  .serial_data_out_pin(serial_data_out_pin),
  .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n),
  .cfg_bidir(cfg_bidir), .cfg_lsb_first(cfg_lsb_first),
  .cfg_user(cfg_user));

// *** verification/dsp_host_model.sv ***
`timescale 1ns/1ps
module dsp_host_model
(
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic host_d,
  output logic host_drv,
  // read wire
  input wire logic rd_w
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_d = 1'b0;
    host_drv = 1'b0;
  end
  task automatic shift(input logic [7:0] b, input int n, input logic lsb,
    input logic rel, output logic [7:0] r);
    int k;
    r = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      k = lsb ? i : 7 - i;
      host_drv = !rel;
      host_d = b[k];
      #16 r[k] = rd_w;
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat,
    input int n, input int zb, input logic lsb, input logic stall,
    output logic [7:0] r);
    #3 cs_n = 1'b0;
    #20 shift(ins, n, lsb, 1'b0, r);
    if (stall)
    begin
      cs_n = 1'b1;
      #100 cs_n = 1'b0;
      #20;
    end
    repeat (zb) shift(8'h00, 8, lsb, 1'b0, r);
    if (n == 8)
      shift(dat, 8, lsb, ins[7], r);
    #16 cs_n = 1'b1;
    host_drv = 1'b0;
    #100;
  endtask
endmodule // dsp_host_model

// *** verification/dsp_serial_port_test.sv ***
`timescale 1ns/1ps
module dsp_serial_port_test;
  import dsp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic bsel = 1'b0;
  logic lsb = 1'b0;
  logic sclk, cs_n, host_d, host_drv, sdio_out, sdio_oe_n, so, so_oe_n;
  logic cfg_bidir, cfg_lsb_first;
  logic [DSP_NUM_USER*DSP_BYTE_W-1:0] cfg_user;
  logic [7:0] got;
  int bad_count = 0;
  int check_count = 0;
  wire sdio_w = !sdio_oe_n ? sdio_out : (host_drv ? host_d : ~host_d);
  wire dout_w = !so_oe_n ? so : ~so;
  wire rd_w = bsel ? sdio_w : dout_w;
  always #10 clk_sys = ~clk_sys;
  dsp_serial_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_w), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .serial_data_out_pin(so),
    .serial_data_out_pin_oe_n(so_oe_n), .cfg_bidir(cfg_bidir),
    .cfg_lsb_first(cfg_lsb_first), .cfg_user(cfg_user),
    .status_in(8'h5A));
  dsp_host_model host (.sclk(sclk), .cs_n(cs_n), .host_d(host_d),
    .host_drv(host_drv), .rd_w(rd_w));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
      $display("ERROR %0t got %h exp %h", $time, g, e);
    if (g !== e)
      bad_count++;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic s);
    host.frame({1'b0, a}, d, 8, 0, lsb, s, got);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host.frame({1'b1, a}, 8'h00, 8, 0, lsb, 1'b0, got);
    chk(got, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(DSP_ADDR_SPCFG, DSP_SPCFG_RST); // default order
    $display("test 1 done");
    for (int i = 0; i < DSP_NUM_USER; i++)
      wr(7'(DSP_ADDR_USER0 + i), 8'(8'h11 * (i + 1)), i[0]); // stall
    repeat (6) @(negedge clk_sys);
    for (int i = 0; i < DSP_NUM_USER; i++)
    begin
      rd(7'(DSP_ADDR_USER0 + i), 8'(8'h11 * (i + 1))); // read
      chk(cfg_user[8*i +: 8], 8'(8'h11 * (i + 1))); // image
    end
    $display("test 2 done");
    wr(DSP_ADDR_STATUS, 8'hFF, 1'b0); // ignored write
    rd(DSP_ADDR_STATUS, 8'h5A); // status kept
    rd(7'h7F, DSP_BYTE_ZERO); // unmapped
    host.frame({1'b0, DSP_ADDR_USER0}, 8'hFF, 5, 0, lsb, 1'b0, got);
    wr(7'h03, 8'hA5, 1'b0); // new frame
    rd(7'h03, 8'hA5); // after abort
    rd(DSP_ADDR_USER0, 8'h11); // untouched
    $display("test 3 done");
    wr(DSP_ADDR_SPCFG, 8'hC0, 1'b0); // mode write
    lsb = 1'b1;
    bsel = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({6'h00, cfg_bidir, cfg_lsb_first}, 8'h03); // flags
    rd(DSP_ADDR_USER0, 8'h11); // new mode
    wr(DSP_ADDR_SPCFG, 8'hE0, 1'b0); // soft reset
    repeat (6) @(negedge clk_sys);
    chk(cfg_user[7:0], DSP_USER_RST); // user cleared
    rd(7'h03, DSP_USER_RST); // user cleared
    rd(DSP_ADDR_SPCFG, 8'hE0); // config kept
    $display("test 4 done");
    host.frame(8'h00, 8'h00, 3, 3, lsb, 1'b0, got); // recovery
    lsb = 1'b0;
    bsel = 1'b0;
    rd(DSP_ADDR_SPCFG, DSP_SPCFG_RST); // recovered
    chk({6'h00, cfg_bidir, cfg_lsb_first}, 8'h00); // flags
    $display("test 5 done");
    wrap_up();
  end
endmodule // dsp_serial_port_test
